// ### verilog/itt_consts.svh
// Offsets, field positions, reset values and timing counts of the inactivity timer
// What this block does
// [RULE1] Timeout, trigger mask and expiry status decode at offsets 0 to 2; offset 3 is reserved.
// [RULE2] Any timeout write releases the expiry output high and sets the status bit to one.
// [RULE3] A non-zero timeout write activates the timer, loads the counter and starts counting.
// [RULE4] A non-zero write while running reloads the counter at once and counting continues.
// [RULE5] Writing zero halts the counter, deactivates the timer and makes all outputs inactive; irq_r stays set while an enabled sticky event is pending.
// [RULE6] The timeout is an 8-bit minute count, 1 to 255, with zero meaning off.
// [RULE7] Reset clears the timeout register, so the timer starts deactivated.
// [RULE8] An enabled interrupt line becoming active while the timer counts reloads the counter and restarts it.
// [RULE9] Mask bits 0 to 3 enable keyboard, mouse, serial 1 and serial 2; 7 to 4 reserved; reset 0.
// [RULE10] Status bit 0 reads the expiry level (0 expired, 1 inactive); bits 7 to 1 read zero.
// [RULE11] The status register is 01h after reset and whenever the timer is activated.
// [RULE12] The counter is an 8-bit down counter stepping once a minute while active.
// [RULE13] On reaching zero the counter stops, the expiry output goes low, status bit clears.
// [RULE14] The assigned interrupt stays asserted as long as the status bit reads zero.
// [RULE15] A prescaler makes the minute tick; trigger lines are synchronised, each assertion of an enabled line reloads while counting.
// [RULE16] A trigger coinciding with a tick wins: the counter reloads instead of decrementing.
`ifndef ITT_CONSTS_SVH
`define ITT_CONSTS_SVH

`define ITT_OFS_TIMEOUT    3'h0
`define ITT_OFS_MASK       3'h1
`define ITT_OFS_STATUS     3'h2
`define ITT_OFS_RESERVED   3'h3
`define ITT_OFS_IRQ_STAT   3'h4
`define ITT_OFS_IRQ_EN     3'h5
`define ITT_OFS_IRQ_CLR    3'h6

`define ITT_TIMEOUT_RST    8'h00
`define ITT_MASK_RST       8'h00
`define ITT_STATUS_RST     8'h01
`define ITT_MASK_BITS      4

`define ITT_EV_EXPIRE      0
`define ITT_EV_RELOAD      1
`define ITT_EV_BITS        2

`define ITT_CLK_HZ         64'd50000000
`define ITT_MINUTE_S       64'd60
`define ITT_MINUTE_CYCLES  (`ITT_MINUTE_S * `ITT_CLK_HZ)

`endif

// ### verilog/itt_pkg.sv
// Types shared by the inactivity timer
package itt_pkg;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } itt_bus_req_type;

  // Bit order matches the trigger mask layout
  typedef struct packed {
    logic ser2;
    logic ser1;
    logic mouse;
    logic keyboardIrqTrigger;
  } itt_trig_lines_type;

  typedef enum logic [2:0] {
    ITT_OFF     = 3'h1,
    ITT_RUN     = 3'h2,
    ITT_EXPIRED = 3'h4
  } itt_state_type;

endpackage

// ### verilog/itt_inactivity_timer.sv
// Inactivity timer: minute countdown reloaded by enabled peripheral interrupts
`timescale 1ns/1ps
`include "itt_consts.svh"

module itt_inactivity_timer #(
  parameter logic [31:0] MINUTE_CYCLES = 32'(`ITT_MINUTE_CYCLES)
) (
  input  wire logic                          mclk,
  input  wire logic                          resetn,
  input  wire itt_pkg::itt_bus_req_type      busReq,
  output logic     [7:0]                     rdata_r,
  input  wire itt_pkg::itt_trig_lines_type   trigLines,
  output logic                               expiryOutN_r,
  output logic                               expiryIrqLevel_r,
  output logic                               irq_r
);

  itt_pkg::itt_state_type   state_r;
  logic [7:0]               timeoutMinutes_r;
  logic [7:0]               triggerEventMask_r;
  logic [7:0]               count_r;
  logic [31:0]              preCnt_r;
  logic [3:0]               trigSync1_r;
  logic [3:0]               trigSync2_r;
  logic [3:0]               trigPrev_r;
  logic [`ITT_EV_BITS-1:0]  irqStat_r;
  logic [`ITT_EV_BITS-1:0]  irqEn_r;
  logic [`ITT_EV_BITS-1:0]  events;
  logic                     wrTimeout;
  logic                     running;
  logic                     minuteTick;
  logic                     trigEvent;
  logic                     reloadNow;
  logic                     expireNow;
  logic [7:0]               expiryStatus;

  assign wrTimeout = busReq.wr && (busReq.addr == `ITT_OFS_TIMEOUT);
  assign running   = (state_r == itt_pkg::ITT_RUN);

  // Two-stage synchroniser on the asynchronous interrupt pins
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      trigSync1_r <= 4'h0;
      trigSync2_r <= 4'h0;
      trigPrev_r  <= 4'h0;
    end else begin
      trigSync1_r <= trigLines;
      trigSync2_r <= trigSync1_r;
      trigPrev_r  <= trigSync2_r;
    end
  end

  // Rising edge only, so a line held high reloads once per assertion
  assign trigEvent = |(trigSync2_r & ~trigPrev_r & triggerEventMask_r[3:0]); // RULE15 RULE8 RULE9

  // Minute prescaler restarts on every load so each period is a full minute
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      preCnt_r <= 32'h0;
    end else if (!running || wrTimeout || trigEvent || minuteTick) begin
      preCnt_r <= 32'h0;
    end else begin
      preCnt_r <= preCnt_r + 32'h1;
    end
  end

  assign minuteTick = running && (preCnt_r == MINUTE_CYCLES - 32'h1); // RULE15

  assign reloadNow = running && !wrTimeout && trigEvent; // RULE16
  assign expireNow = running && !wrTimeout && !trigEvent && minuteTick
                     && (count_r == 8'h01);

  // Register writes
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      timeoutMinutes_r   <= `ITT_TIMEOUT_RST; // RULE7
      triggerEventMask_r <= `ITT_MASK_RST;
    end else if (busReq.wr) begin
      case (busReq.addr)
        `ITT_OFS_TIMEOUT: begin
          timeoutMinutes_r <= busReq.wdata; // RULE6
        end
        `ITT_OFS_MASK: begin
          // Reserved upper bits are kept at zero
          triggerEventMask_r <= {4'h0, busReq.wdata[3:0]}; // RULE9
        end
        default: begin
        end
      endcase
    end
  end

  // Timer state and countdown
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_r <= itt_pkg::ITT_OFF;
      count_r <= 8'h00;
    end else if (wrTimeout) begin
      if (busReq.wdata != 8'h00) begin
        state_r <= itt_pkg::ITT_RUN; // RULE3 RULE4
        count_r <= busReq.wdata;
      end else begin
        state_r <= itt_pkg::ITT_OFF; // RULE5
        count_r <= 8'h00;
      end
    end else begin
      case (state_r)
        itt_pkg::ITT_OFF: begin
          state_r <= itt_pkg::ITT_OFF;
        end
        itt_pkg::ITT_RUN: begin
          if (reloadNow) begin
            count_r <= timeoutMinutes_r; // RULE8 RULE16
          end else if (expireNow) begin
            count_r <= 8'h00; // RULE13
            state_r <= itt_pkg::ITT_EXPIRED;
          end else if (minuteTick) begin
            count_r <= count_r - 8'h01; // RULE12
          end
        end
        itt_pkg::ITT_EXPIRED: begin
          // Counter stays at zero until software writes the timeout
          state_r <= itt_pkg::ITT_EXPIRED;
        end
        default: begin
          state_r <= itt_pkg::ITT_OFF;
        end
      endcase
    end
  end

  // Active-low expiry output; its level is also the status bit
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      expiryOutN_r <= 1'b1; // RULE11
    end else if (wrTimeout) begin
      expiryOutN_r <= 1'b1; // RULE2 RULE5 RULE11
    end else if (expireNow) begin
      expiryOutN_r <= 1'b0; // RULE13
    end
  end

  assign expiryStatus = {7'h00, expiryOutN_r}; // RULE10

  // Level for an interrupt line routed to the timer, one cycle behind the status bit
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      expiryIrqLevel_r <= 1'b0;
    end else begin
      expiryIrqLevel_r <= !expiryOutN_r; // RULE14
    end
  end

  // Sticky event status; a new event beats a clear in the same cycle
  assign events = {reloadNow, expireNow};

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irqStat_r <= '0;
      irqEn_r   <= '0;
    end else begin
      if (busReq.wr && busReq.addr == `ITT_OFS_IRQ_CLR) begin
        irqStat_r <= (irqStat_r & ~busReq.wdata[`ITT_EV_BITS-1:0]) | events;
      end else begin
        irqStat_r <= irqStat_r | events;
      end
      if (busReq.wr && busReq.addr == `ITT_OFS_IRQ_EN) begin
        irqEn_r <= busReq.wdata[`ITT_EV_BITS-1:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irqStat_r & irqEn_r);
    end
  end

  // Read data stands only in the cycle after the read strobe
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 8'h00;
    end else if (busReq.rd) begin
      case (busReq.addr)
        `ITT_OFS_TIMEOUT:  rdata_r <= timeoutMinutes_r; // RULE1
        `ITT_OFS_MASK:     rdata_r <= triggerEventMask_r; // RULE1
        `ITT_OFS_STATUS:   rdata_r <= expiryStatus; // RULE1 RULE10
        `ITT_OFS_IRQ_STAT: rdata_r <= {6'h00, irqStat_r};
        `ITT_OFS_IRQ_EN:   rdata_r <= {6'h00, irqEn_r};
        default:           rdata_r <= 8'h00; // RULE1
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  sequence s_wrTimeout(logic nz);
    wrTimeout && ((busReq.wdata != 8'h00) == nz);
  endsequence

  sequence s_lastMinute;
    running && minuteTick && count_r == 8'h01 && !trigEvent && !wrTimeout;
  endsequence

  property p_reservedRead;
    busReq.rd && busReq.addr == `ITT_OFS_RESERVED |=> rdata_r == 8'h00;
  endproperty
  a_reservedRead: assert property (p_reservedRead) // RULE1
    else $error("reserved offset did not read zero");

  property p_writeReleases;
    wrTimeout |=> expiryOutN_r && expiryStatus == `ITT_STATUS_RST;
  endproperty
  a_writeReleases: assert property (p_writeReleases) // RULE2
    else $error("timeout write did not release expiry");

  property p_startLoads;
    s_wrTimeout(1'b1) |=> running && count_r == $past(busReq.wdata)
                          && timeoutMinutes_r == $past(busReq.wdata);
  endproperty
  a_startLoads: assert property (p_startLoads) // RULE3
    else $error("non-zero write did not start countdown");

  property p_zeroStops;
    s_wrTimeout(1'b0) |=> state_r == itt_pkg::ITT_OFF && expiryOutN_r
                          ##1 !expiryIrqLevel_r;
  endproperty
  a_zeroStops: assert property (p_zeroStops) // RULE5
    else $error("zero write did not deactivate");

  property p_triggerReload;
    running && trigEvent && !wrTimeout |=> count_r == timeoutMinutes_r;
  endproperty
  a_triggerReload: assert property (p_triggerReload) // RULE8
    else $error("trigger did not reload counter");

  property p_minuteStep;
    running && minuteTick && count_r > 8'h01 && !trigEvent && !wrTimeout
      |=> count_r == $past(count_r) - 8'h01 && running;
  endproperty
  a_minuteStep: assert property (p_minuteStep) // RULE12
    else $error("counter did not step once");

  property p_expire;
    s_lastMinute |=> !expiryOutN_r && count_r == 8'h00
                     ##1 expiryIrqLevel_r && irqStat_r[`ITT_EV_EXPIRE];
  endproperty
  a_expire: assert property (p_expire) // RULE13
    else $error("expiry sequence wrong");

  property p_statusRead;
    busReq.rd && busReq.addr == `ITT_OFS_STATUS |=> rdata_r == {7'h00, $past(expiryOutN_r)};
  endproperty
  a_statusRead: assert property (p_statusRead) // RULE10
    else $error("status read mismatch");

  property p_irqLevel;
    !expiryOutN_r && !wrTimeout |=> expiryIrqLevel_r;
  endproperty
  a_irqLevel: assert property (p_irqLevel) // RULE14
    else $error("routed interrupt not held");

  property p_maskedIgnored;
    running && !wrTimeout && !minuteTick && !trigEvent |=> count_r == $past(count_r);
  endproperty
  a_maskedIgnored: assert property (p_maskedIgnored) // RULE9
    else $error("counter moved without cause");

  property p_tickPriority;
    running && minuteTick && trigEvent && !wrTimeout |=> count_r == timeoutMinutes_r
                                                         && expiryOutN_r;
  endproperty
  a_tickPriority: assert property (p_tickPriority) // RULE16
    else $error("tick won over trigger");

  property p_offDormant;
    state_r == itt_pkg::ITT_OFF |-> expiryOutN_r && count_r == 8'h00;
  endproperty
  a_offDormant: assert property (p_offDormant) // RULE5
    else $error("idle timer not at inactive levels");

  property p_haltWhenOff;
    state_r == itt_pkg::ITT_OFF && !wrTimeout
      |=> state_r == itt_pkg::ITT_OFF && !expiryIrqLevel_r && preCnt_r == 32'h0;
  endproperty
  a_haltWhenOff: assert property (p_haltWhenOff) // RULE5
    else $error("halted timer moved");

  property p_expiredHolds;
    state_r == itt_pkg::ITT_EXPIRED && !wrTimeout
      |=> state_r == itt_pkg::ITT_EXPIRED && count_r == 8'h00 && !expiryOutN_r;
  endproperty
  a_expiredHolds: assert property (p_expiredHolds) // RULE13
    else $error("expired counter did not stay stopped");

  property p_runReleased;
    running |-> expiryOutN_r && expiryStatus == `ITT_STATUS_RST;
  endproperty
  a_runReleased: assert property (p_runReleased) // RULE11
    else $error("active timer shows expired status");

  property p_maskWrite;
    busReq.wr && busReq.addr == `ITT_OFS_MASK
      |=> triggerEventMask_r[3:0] == $past(busReq.wdata[3:0])
          && triggerEventMask_r[7:4] == 4'h0;
  endproperty
  a_maskWrite: assert property (p_maskWrite) // RULE9
    else $error("mask write not held as written");

  property p_fallOnlyAtZero;
    $fell(expiryOutN_r) |-> $past(running) && $past(minuteTick) && $past(count_r) == 8'h01;
  endproperty
  a_fallOnlyAtZero: assert property (p_fallOnlyAtZero) // RULE13
    else $error("expiry asserted before the count ran out");

  property p_riseOnlyByWrite;
    $rose(expiryOutN_r) |-> $past(wrTimeout);
  endproperty
  a_riseOnlyByWrite: assert property (p_riseOnlyByWrite) // RULE2
    else $error("expiry released without a timeout write");

  property p_reloadRestartsMinute;
    reloadNow |=> preCnt_r == 32'h0 && count_r == $past(timeoutMinutes_r);
  endproperty
  a_reloadRestartsMinute: assert property (p_reloadRestartsMinute) // RULE15
    else $error("reload did not restart the minute");

  property p_timeoutRead;
    busReq.rd && busReq.addr == `ITT_OFS_TIMEOUT |=> rdata_r == $past(timeoutMinutes_r);
  endproperty
  a_timeoutRead: assert property (p_timeoutRead) // RULE6
    else $error("timeout read mismatch");

  property p_readIdle;
    !busReq.rd |=> rdata_r == 8'h00;
  endproperty
  a_readIdle: assert property (p_readIdle) // RULE1
    else $error("read data stood past its cycle");

endmodule

// ### bench/itt_irq_source.sv
// Peripheral interrupt lines feeding the timer's trigger inputs
`timescale 1ns/1ps

module itt_irq_source (
  input  wire logic                   mclk,
  output itt_pkg::itt_trig_lines_type trigLines
);
  logic [3:0] lineBits = 4'h0;

  assign trigLines = itt_pkg::itt_trig_lines_type'(lineBits);

  // Held four cycles: a narrower pulse could slip past the synchroniser
  task automatic pulse(input int idx);
    @(posedge mclk);
    lineBits[idx] <= 1'b1;
    repeat (4) @(posedge mclk);
    lineBits[idx] <= 1'b0;
  endtask
endmodule

// ### bench/itt_inactivity_timer_bench.sv
// Self-checking bench for the inactivity timer
`timescale 1ns/1ps

module itt_inactivity_timer_bench;
  localparam int MC = 20;

  logic                        mclk;
  logic                        resetn;
  itt_pkg::itt_bus_req_type    busReq;
  logic [7:0]                  rdata;
  itt_pkg::itt_trig_lines_type trigLines;
  logic                        expiryOutN;
  logic                        expiryIrqLevel;
  logic                        irq;
  int                          mismatches;
  int                          compares;

  itt_inactivity_timer #(.MINUTE_CYCLES(32'(MC))) i_itt_inactivity_timer (
    .mclk             (mclk),
    .resetn           (resetn),
    .busReq           (busReq),
    .rdata_r          (rdata),
    .trigLines        (trigLines),
    .expiryOutN_r     (expiryOutN),
    .expiryIrqLevel_r (expiryIrqLevel),
    .irq_r            (irq)
  );

  itt_irq_source i_itt_irq_source (
    .mclk      (mclk),
    .trigLines (trigLines)
  );

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    busReq.wr <= 1'b0;
  endtask

  task automatic rdc(input logic [2:0] a, input logic [7:0] exp, input string what);
    @(posedge mclk);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    busReq.rd <= 1'b0;
    #1;
    check(what, rdata, exp);
  endtask

  // Cycles until the expiry output falls must land inside lo..hi
  task automatic waitLow(input int lo, input int hi, input string what);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (expiryOutN !== 1'b0 && n < 400);
    check(what, {7'h00, (n >= lo && n <= hi)}, 8'h01);
  endtask

  task automatic results();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    results();
  end

  initial begin
    mismatches = 0;
    compares = 0;
    resetn = 1'b0;
    busReq = '0;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    rdc(3'h0, 8'h00, "timeout reset");
    rdc(3'h1, 8'h00, "mask reset");
    rdc(3'h2, 8'h01, "status reset");
    check("expiry pin reset", {7'h00, expiryOutN}, 8'h01);
    wr(3'h1, 8'hFF);
    rdc(3'h1, 8'h0F, "mask reserved bits");
    wr(3'h2, 8'h00);
    rdc(3'h2, 8'h01, "status read only");
    wr(3'h3, 8'hAA);
    rdc(3'h3, 8'h00, "reserved offset");
    // Countdown to expiry with the interrupt enabled
    wr(3'h5, 8'h01);
    wr(3'h0, 8'h02);
    waitLow(2 * MC - 2, 2 * MC + 4, "two minute expiry");
    rdc(3'h2, 8'h00, "status expired");
    rdc(3'h0, 8'h02, "timeout value");
    check("routed level", {7'h00, expiryIrqLevel}, 8'h01);
    check("irq raised", {7'h00, irq}, 8'h01);
    rdc(3'h4, 8'h01, "irq status");
    wr(3'h6, 8'h01);
    cyc(2);
    check("irq cleared", {7'h00, irq}, 8'h00);
    // Zero write releases the outputs and halts
    wr(3'h0, 8'h00);
    cyc(2);
    check("release on write", {7'h00, expiryOutN}, 8'h01);
    check("routed level off", {7'h00, expiryIrqLevel}, 8'h00);
    rdc(3'h2, 8'h01, "status released");
    cyc(3 * MC);
    check("halted", {7'h00, expiryOutN}, 8'h01);
    // Masked interrupt stays low, status stays sticky
    wr(3'h5, 8'h00);
    wr(3'h0, 8'h01);
    waitLow(MC - 2, MC + 4, "one minute expiry");
    cyc(2);
    check("irq masked", {7'h00, irq}, 8'h00);
    rdc(3'h4, 8'h01, "irq status sticky");
    wr(3'h6, 8'h03);
    // Restart from expired, then reload while running
    wr(3'h0, 8'h01);
    rdc(3'h2, 8'h01, "status on activation");
    cyc(MC - 10);
    wr(3'h0, 8'h02);
    waitLow(2 * MC - 2, 2 * MC + 4, "reload by write");
    // Each trigger line, enabled alone and masked alone
    for (int i = 0; i < 4; i++) begin
      for (int en = 0; en < 2; en++) begin
        wr(3'h1, (en == 1) ? (8'h01 << i) : (8'h0F & ~(8'h01 << i)));
        wr(3'h0, 8'h01);
        cyc(MC - 6);
        i_itt_irq_source.pulse(i);
        if (en == 1)
          waitLow(MC - 3, MC + 4, "trigger reload");
        else
          waitLow(0, 6, "trigger masked");
      end
    end
    rdc(3'h4, 8'h03, "irq status reload");
    results();
  end
endmodule
